// ==== virq_pkg.sv ====
// Package with register offsets, field positions, vectors and timing for the interrupt controller.
package virq_pkg;
    localparam int          NUM_SRC      = 18;
    localparam int          SRC_W        = 5;
    localparam logic [7:0]  OFS_IRQ_ENABLE_GROUP0     = 8'h00_A8;
    localparam logic [7:0]  OFS_IRQ_ENABLE_GROUP1     = 8'h00_B8;
    localparam logic [7:0]  OFS_IRQ_ENABLE_GROUP2     = 8'h00_9A;
    localparam logic [7:0]  OFS_PRIO0    = 8'h00_A9;
    localparam logic [7:0]  OFS_PRIO1    = 8'h00_B9;
    localparam logic [7:0]  OFS_FLAG0    = 8'h00_88;
    localparam logic [7:0]  OFS_FLAG1    = 8'h00_C0;
    localparam logic [7:0]  OFS_FLAG2    = 8'h00_E8;
    localparam int          GLOBAL_BIT   = 7;
    localparam logic [7:0]  IRQ_ENABLE_GROUP0_MASK    = 8'h00_BF;
    localparam logic [7:0]  IEN12_MASK   = 8'h00_3F;
    localparam logic [7:0]  PRIO_MASK    = 8'h00_3F;
    localparam logic [7:0]  REG_RESET    = 8'h00_00;
    localparam logic [7:0]  VEC_BASE     = 8'h00_03;
    localparam logic [7:0]  VEC_STEP     = 8'h00_08;
    localparam int          NUM_GROUPS   = 6;
    localparam int          DETECT_CYC   = 1;
    localparam int          CALL_CYC     = 6;
    localparam int          ACK_CYC      = DETECT_CYC + CALL_CYC;
    localparam logic [2:0]  CALL_CNT     = 3'(CALL_CYC - 1);
    // Source numbers that carry shared or named functions.
    localparam int          SRC_RADIO_TXRX = 0;
    localparam int          SRC_SER1_RX    = 3;
    localparam int          SRC_PORT2      = 6;
    localparam int          SRC_PORT0      = 13;
    localparam int          SRC_SER1_TX    = 14;
    localparam int          SRC_WATCHDOG   = 17;

    typedef enum logic [2:0] {
        VIRQ_IDLE   = 3'b001,
        VIRQ_DETECT = 3'b010,
        VIRQ_CALL   = 3'b100
    } virq_state_t;
endpackage

// ==== virq_prio_pick.sv ====
// Picks the highest-priority eligible source from a request vector.
`timescale 1ns/1ps
`default_nettype none
module virq_prio_pick
    import virq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic [N-1:0]     req,
    input  wire logic [2*N-1:0]   lvl,
    output logic                  any,
    output logic [SRC_W-1:0]      idx,
    output logic [1:0]            bestLvl
);
    initial begin
        if (N < 1 || N > 32) $error("virq_prio_pick: N out of range");
    end

    // Higher level wins; among equal levels the lower source number wins.
    always_comb begin
        any     = 1'b0;
        idx     = '0;
        bestLvl = 2'd0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!any || lvl[2*i +: 2] > bestLvl)) begin
                any     = 1'b1;
                idx     = SRC_W'(i);
                bestLvl = lvl[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// ==== virq_flag_bit.sv ====
// One interrupt request flag: set by its event, cleared by software or acknowledge.
`timescale 1ns/1ps
`default_nettype none
module virq_flag_bit (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic setEvt,
    input  wire logic clrEvt,
    output logic      flag
);
    // A set in the same cycle as a clear wins so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (setEvt) begin
            flag <= 1'b1;
        end else if (clrEvt) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== vectored_irq_mask_controller.sv ====
// Interrupt flag collection, masking, priority selection and vectoring for the core.
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_mask_controller
    import virq_pkg::*;
#(
    parameter int N_SRC      = NUM_SRC,
    parameter int PORT0_SUBS = 8,
    parameter int MERGE_SUBS = 8
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic [N_SRC-1:0]      srcEvt,
    input  wire logic [PORT0_SUBS-1:0] port0Evt,
    input  wire logic [PORT0_SUBS-1:0] port0Mask,
    input  wire logic                  port0_line7,
    input  wire logic                  usbPending,
    input  wire logic                  audioRxDone,
    input  wire logic                  audioTxDone,
    input  wire logic [MERGE_SUBS-1:0] radioEvt,
    input  wire logic [MERGE_SUBS-1:0] radioMask,
    input  wire logic                  sfrWr,
    input  wire logic                  sfrRd,
    input  wire logic [7:0]            sfrAddr,
    input  wire logic [7:0]            sfrWdata,
    input  wire logic                  coreCallDone,
    input  wire logic                  coreReti,
    output logic [7:0]                 sfrRdata,
    output logic                       irqReq,
    output logic [7:0]                 irqVector,
    output logic [SRC_W-1:0]           irqSrc,
    output logic                       irqAck,
    output logic                       inService
);
    initial begin
        if (N_SRC != NUM_SRC) $error("vectored_irq_mask_controller: N_SRC must be 18");
        if (PORT0_SUBS < 8) $error("vectored_irq_mask_controller: PORT0_SUBS below 8");
        if (MERGE_SUBS < 1) $error("vectored_irq_mask_controller: MERGE_SUBS below 1");
    end

    logic [7:0]           irq_enable_group0_r;
    logic [7:0]           irq_enable_group1_r;
    logic [7:0]           irq_enable_group2_r;
    logic [7:0]           prio0_r;
    logic [7:0]           prio1_r;
    logic [N_SRC-1:0]     flags;
    logic [N_SRC-1:0]     flagSet;
    logic [N_SRC-1:0]     flagClr;
    logic [N_SRC-1:0]     enables;
    logic [N_SRC-1:0]     eligible;
    logic [2*N_SRC-1:0]   srcLvl;
    logic                 pickAny;
    logic [SRC_W-1:0]     pickIdx;
    logic [1:0]           pickLvl;
    virq_state_t          state_r;
    virq_state_t          state_nxt;
    logic [2:0]           callCnt_r;
    logic [SRC_W-1:0]     ackSrc_r;
    logic [3:0]           svcMask_r;
    logic [3:0]           svcMask_nxt;
    logic [1:0]           svcLvl;
    logic                 svcActive;
    logic                 global_irq_enable;
    logic                 preemptOk;
    logic                 flagWr0;
    logic                 flagWr1;
    logic                 flagWr2;

    // Enable registers in the special-function space.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq_enable_group0_r <= REG_RESET;
            irq_enable_group1_r <= REG_RESET;
            irq_enable_group2_r <= REG_RESET;
        end else if (sfrWr) begin
            if (sfrAddr == OFS_IRQ_ENABLE_GROUP0) irq_enable_group0_r <= sfrWdata & IRQ_ENABLE_GROUP0_MASK;
            if (sfrAddr == OFS_IRQ_ENABLE_GROUP1) irq_enable_group1_r <= sfrWdata & IEN12_MASK;
            if (sfrAddr == OFS_IRQ_ENABLE_GROUP2) irq_enable_group2_r <= sfrWdata & IEN12_MASK;
        end
    end

    // Two-bit priority level for each of six groups, split over two registers.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prio0_r <= REG_RESET;
            prio1_r <= REG_RESET;
        end else if (sfrWr) begin
            if (sfrAddr == OFS_PRIO0) prio0_r <= sfrWdata & PRIO_MASK;
            if (sfrAddr == OFS_PRIO1) prio1_r <= sfrWdata & PRIO_MASK;
        end
    end

    assign global_irq_enable = irq_enable_group0_r[GLOBAL_BIT];

    // Source-to-enable map: 0-5 in group 0, 8-13 in group 1, the rest in group 2.
    always_comb begin
        enables     = '0;
        enables[0]  = irq_enable_group0_r[0];
        enables[1]  = irq_enable_group0_r[1];
        enables[2]  = irq_enable_group0_r[2];
        enables[3]  = irq_enable_group0_r[3];
        enables[4]  = irq_enable_group0_r[4];
        enables[5]  = irq_enable_group0_r[5];
        enables[6]  = irq_enable_group2_r[1];
        enables[7]  = irq_enable_group2_r[2];
        enables[8]  = irq_enable_group1_r[0];
        enables[9]  = irq_enable_group1_r[1];
        enables[10] = irq_enable_group1_r[2];
        enables[11] = irq_enable_group1_r[3];
        enables[12] = irq_enable_group1_r[4];
        enables[13] = irq_enable_group1_r[5];
        enables[14] = irq_enable_group2_r[3];
        enables[15] = irq_enable_group2_r[4];
        enables[16] = irq_enable_group2_r[0];
        enables[17] = irq_enable_group2_r[5];
    end

    // Flag set sources, including merged and shared events.
    always_comb begin
        flagSet = srcEvt;
        flagSet[SRC_SER1_RX] = srcEvt[SRC_SER1_RX] | audioRxDone;
        flagSet[SRC_SER1_TX] = srcEvt[SRC_SER1_TX] | audioTxDone;
        flagSet[SRC_PORT2]   = srcEvt[SRC_PORT2] | usbPending;
        flagSet[SRC_PORT0]   = srcEvt[SRC_PORT0] | |(port0Evt & port0Mask)
                               | (port0_line7 & port0Mask[7]);
        flagSet[SRC_RADIO_TXRX] = srcEvt[SRC_RADIO_TXRX];
        flagSet[16] = srcEvt[16] | |(radioEvt & radioMask);
    end

    // Flags live in three flag registers; a write of 0 to a bit clears it.
    assign flagWr0 = sfrWr && (sfrAddr == OFS_FLAG0);
    assign flagWr1 = sfrWr && (sfrAddr == OFS_FLAG1);
    assign flagWr2 = sfrWr && (sfrAddr == OFS_FLAG2);

    always_comb begin
        flagClr = '0;
        for (int i = 0; i < 8; i++) begin
            flagClr[i] = flagWr0 && !sfrWdata[i];
            if (i + 8 < N_SRC) flagClr[i+8] = flagWr1 && !sfrWdata[i];
            if (i + 16 < N_SRC) flagClr[i+16] = flagWr2 && !sfrWdata[i];
        end
        if (irqAck) flagClr[ackSrc_r] = 1'b1;
    end

    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : gFlag
            virq_flag_bit uFlag (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .setEvt  (flagSet[g]),
                .clrEvt  (flagClr[g]),
                .flag    (flags[g])
            );
        end
    endgenerate

    // Each source inherits its group's level; groups hold sources n, n+6 and n+12.
    always_comb begin
        srcLvl = '0;
        for (int i = 0; i < N_SRC; i++) begin
            srcLvl[2*i +: 2] = {prio1_r[i % NUM_GROUPS], prio0_r[i % NUM_GROUPS]};
        end
    end

    assign eligible = flags & enables & {N_SRC{global_irq_enable}};

    virq_prio_pick #(
        .N (N_SRC)
    ) uPick (
        .req     (eligible),
        .lvl     (srcLvl),
        .any     (pickAny),
        .idx     (pickIdx),
        .bestLvl (pickLvl)
    );

    assign preemptOk = !svcActive || (pickLvl > svcLvl);

    // Acknowledge sequence: one detect cycle, then six call cycles.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            VIRQ_IDLE: begin
                if (pickAny && preemptOk) state_nxt = VIRQ_DETECT;
            end
            VIRQ_DETECT: begin
                state_nxt = VIRQ_CALL;
            end
            VIRQ_CALL: begin
                if (callCnt_r == 3'd0) state_nxt = VIRQ_IDLE;
            end
            default: begin
                state_nxt = VIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= VIRQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            callCnt_r <= 3'd0;
        end else if (state_r == VIRQ_DETECT) begin
            callCnt_r <= CALL_CNT;
        end else if (state_r == VIRQ_CALL && callCnt_r != 3'd0) begin
            callCnt_r <= callCnt_r - 3'd1;
        end
    end

    // Captured source and vector stay stable through the call.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ackSrc_r  <= '0;
            irqVector <= VEC_BASE;
        end else if (state_r == VIRQ_IDLE && pickAny && preemptOk) begin
            ackSrc_r  <= pickIdx;
            irqVector <= VEC_BASE + 8'(pickIdx) * VEC_STEP;
        end
    end

    // One in-service bit per level; a return retires only the highest level, so a
    // preempted routine still holds off requests of its own level or lower.
    always_comb begin
        svcActive = |svcMask_r;
        svcLvl    = 2'd0;
        for (int i = 0; i < 4; i++) begin
            if (svcMask_r[i]) svcLvl = 2'(i);
        end
    end

    always_comb begin
        svcMask_nxt = svcMask_r;
        if (coreReti && svcActive) svcMask_nxt[svcLvl] = 1'b0;
        if (irqAck) svcMask_nxt[srcLvl[2*ackSrc_r +: 2]] = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            svcMask_r <= 4'h0;
        end else begin
            svcMask_r <= svcMask_nxt;
        end
    end

    assign irqReq    = (state_r != VIRQ_IDLE);
    assign irqSrc    = ackSrc_r;
    assign irqAck    = (state_r == VIRQ_CALL) && (callCnt_r == 3'd0);
    assign inService = svcActive;

    // Register read port; unlisted addresses return zero.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sfrRdata <= 8'h00_00;
        end else if (sfrRd) begin
            case (sfrAddr)
                OFS_IRQ_ENABLE_GROUP0:  sfrRdata <= irq_enable_group0_r;
                OFS_IRQ_ENABLE_GROUP1:  sfrRdata <= irq_enable_group1_r;
                OFS_IRQ_ENABLE_GROUP2:  sfrRdata <= irq_enable_group2_r;
                OFS_PRIO0: sfrRdata <= prio0_r;
                OFS_PRIO1: sfrRdata <= prio1_r;
                OFS_FLAG0: sfrRdata <= flags[7:0];
                OFS_FLAG1: sfrRdata <= flags[15:8];
                OFS_FLAG2: sfrRdata <= {6'd0, flags[17:16]};
                default:   sfrRdata <= 8'h00_00;
            endcase
        end
    end

    logic unusedCallDone;
    assign unusedCallDone = coreCallDone;
endmodule
`default_nettype wire

// ==== virq_asserts.sv ====
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/1ps
`default_nettype none
module virq_asserts
    import virq_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic             sfrWr,
    input wire logic             sfrRd,
    input wire logic [7:0]       sfrAddr,
    input wire logic [7:0]       sfrWdata,
    input wire logic             coreReti,
    input wire logic [7:0]       sfrRdata,
    input wire logic             irqReq,
    input wire logic [7:0]       irqVector,
    input wire logic [SRC_W-1:0] irqSrc,
    input wire logic             irqAck,
    input wire logic             inService
);
    logic [7:0] enSh_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            enSh_r <= REG_RESET;
        end else if (sfrWr && sfrAddr == OFS_IRQ_ENABLE_GROUP0) begin
            enSh_r <= sfrWdata & IRQ_ENABLE_GROUP0_MASK;
        end
    end
    ack_time_a: assert property ($rose(irqReq) |-> !irqAck [*6] ##1 irqAck)
        else $error("acknowledge not on seventh request cycle");
    req_hold_a: assert property ($rose(irqReq) |-> irqReq [*7] ##1 !irqReq)
        else $error("request not held for seven cycles");
    vec_map_a: assert property (irqReq |-> irqVector == 8'(VEC_BASE + VEC_STEP * irqSrc))
        else $error("vector does not match source");
    src_range_a: assert property (irqReq |-> irqSrc < 5'(NUM_SRC))
        else $error("source number out of range");
    glob_gate_a: assert property ($rose(irqReq) |-> $past(enSh_r[GLOBAL_BIT]))
        else $error("request raised with global enable clear");
    src_mask_a: assert property ($rose(irqReq) && irqSrc < 5'd6 |->
        ($past(enSh_r) & (8'h01 << irqSrc)) != 8'h00) else $error("masked source requested");
    ack_svc_a: assert property (irqAck |=> inService && !irqAck)
        else $error("acknowledge did not start service");
    svc_end_a: assert property ($fell(inService) |-> $past(coreReti))
        else $error("service ended without return");
    en_read_a: assert property (sfrRd && sfrAddr == OFS_IRQ_ENABLE_GROUP0 |=> sfrRdata == $past(enSh_r))
        else $error("enable register read mismatch");
endmodule
bind vectored_irq_mask_controller virq_asserts chk (.sys_clk, .nrst, .sfrWr, .sfrRd, .sfrAddr,
    .sfrWdata, .coreReti, .sfrRdata, .irqReq, .irqVector, .irqSrc, .irqAck, .inService);
`default_nettype wire

// ==== virq_core_model.sv ====
// Core model that takes acknowledged calls and returns after a set service time.
`timescale 1ns/1ps
`default_nettype none
module virq_core_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       irqAck,
    input  wire logic [7:0] holdCyc,
    output logic            coreReti
);
    int depth;
    int waitCnt;
    initial coreReti = 1'b0;
    // Nested calls return one at a time, each after the full service time.
    always @(posedge sys_clk) begin
        coreReti <= 1'b0;
        if (!nrst) begin
            depth = 0;
            waitCnt = 0;
        end else if (irqAck) begin
            depth++;
            waitCnt = holdCyc;
        end else if (waitCnt > 0) begin
            waitCnt--;
        end else if (depth > 0) begin
            depth--;
            coreReti <= 1'b1;
            waitCnt = holdCyc;
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
    import virq_pkg::*;
    logic             sys_clk = 1'b0;
    logic             nrst = 1'b0;
    logic [17:0]      srcEvt = '0;
    logic [7:0]       port0Evt = 8'h00, port0Mask = 8'h00, radioEvt = 8'h00, radioMask = 8'h00;
    logic             port0_line7 = 1'b0, usbPending = 1'b0, audioRxDone = 1'b0, audioTxDone = 1'b0;
    logic             sfrWr = 1'b0, sfrRd = 1'b0;
    logic [7:0]       sfrAddr = 8'h00, sfrWdata = 8'h00, holdCyc = 8'h02;
    logic             coreReti, irqReq, irqAck, inService;
    logic [7:0]       sfrRdata, irqVector;
    logic [SRC_W-1:0] irqSrc;
    int               fails = 0, checks = 0, cyc = 0, n;
    int               cipher_done[18] = '{0, 1, 2, 3, 4, 5, 17, 18, 8, 9, 10, 11, 12, 13, 19, 20, 16, 21};
    int               alt[6] = '{3, 14, 6, 13, 13, 16};
    int               q[$];
    vectored_irq_mask_controller dut (.sys_clk, .nrst, .srcEvt, .port0Evt, .port0Mask,
        .port0_line7, .usbPending, .audioRxDone, .audioTxDone, .radioEvt, .radioMask, .sfrWr,
        .sfrRd, .sfrAddr, .sfrWdata, .coreCallDone(1'b0), .coreReti, .sfrRdata, .irqReq,
        .irqVector, .irqSrc, .irqAck, .inService);
    virq_core_model core (.sys_clk, .nrst, .irqAck, .holdCyc, .coreReti);
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    function automatic logic [7:0] fAddr(input int s);
        return s < 8 ? OFS_FLAG0 : (s < 16 ? OFS_FLAG1 : OFS_FLAG2);
    endfunction
    function automatic logic [7:0] fBit(input int s);
        return 8'(1 << (s % 8));
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfrWr <= 1'b1;
        sfrAddr <= a;
        sfrWdata <= d;
        @(posedge sys_clk);
        sfrWr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        sfrRd <= 1'b1;
        sfrAddr <= a;
        @(posedge sys_clk);
        sfrRd <= 1'b0;
        @(negedge sys_clk);
        `CHK(sfrRdata, e)
    endtask
    // The global enable goes last, so no source is live half-configured.
    task automatic setEn(input logic [23:0] e);
        wr(OFS_IRQ_ENABLE_GROUP1, e[15:8]);
        wr(OFS_IRQ_ENABLE_GROUP2, e[23:16]);
        wr(OFS_IRQ_ENABLE_GROUP0, e[7:0]);
    endtask
    task automatic waitReq(input int lim);
        for (n = 0; n < lim && irqReq !== 1'b1; n++) @(negedge sys_clk);
        `CHK(irqReq, 1'b1)
    endtask
    task automatic waitAck();
        for (n = 0; n < 12 && irqAck !== 1'b1; n++) @(negedge sys_clk);
        `CHK(irqAck, 1'b1)
        @(negedge sys_clk);
        `CHK(inService, 1'b1)
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        int          s, a, b, la, lb, hi, lo;
        logic [23:0] e;
        logic [15:0] p;
        logic [7:0]  v, m;
        void'($urandom(26));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rdc(OFS_IRQ_ENABLE_GROUP0, REG_RESET);
        rdc(OFS_IRQ_ENABLE_GROUP2, REG_RESET);
        rdc(8'h00, 8'h00);
        wr(OFS_IRQ_ENABLE_GROUP0, 8'hFF);
        rdc(OFS_IRQ_ENABLE_GROUP0, IRQ_ENABLE_GROUP0_MASK);
        wr(OFS_IRQ_ENABLE_GROUP1, 8'hFF);
        rdc(OFS_IRQ_ENABLE_GROUP1, IEN12_MASK);
        for (s = 0; s < NUM_SRC; s++) begin
            e = 24'h3F_3FBF;
            e[cipher_done[s]] = 1'b0;
            setEn(e);
            @(posedge sys_clk);
            srcEvt[s] <= 1'b1;
            @(posedge sys_clk);
            srcEvt <= '0;
            repeat (12) @(negedge sys_clk);
            `CHK(irqReq, 1'b0)
            rdc(fAddr(s), fBit(s));
            wr(OFS_IRQ_ENABLE_GROUP0, 8'h3F);
            setEn(24'h3F_3F3F);
            repeat (12) @(negedge sys_clk);
            `CHK(irqReq, 1'b0)
            setEn(24'h3F_3FBF);
            waitReq(20);
            `CHK(irqSrc, 5'(s))
            `CHK(irqVector, 8'(3 + 8 * s))
            waitAck();
            rdc(fAddr(s), 8'h00);
            for (n = 0; n < 100 && inService !== 1'b0; n++) @(negedge sys_clk);
            `CHK(inService, 1'b0)
        end
        wr(OFS_IRQ_ENABLE_GROUP0, 8'h00);
        for (a = 0; a < 6; a++) begin
            v = 8'($urandom);
            m = 8'($urandom);
            s = alt[a];
            @(posedge sys_clk);
            port0Mask <= m;
            radioMask <= m;
            case (a)
                0: audioRxDone <= 1'b1;
                1: audioTxDone <= 1'b1;
                2: usbPending <= 1'b1;
                3: port0_line7 <= 1'b1;
                4: port0Evt <= v;
                default: radioEvt <= v;
            endcase
            @(posedge sys_clk);
            {audioRxDone, audioTxDone, usbPending, port0_line7} <= 4'h0;
            port0Evt <= 8'h00;
            radioEvt <= 8'h00;
            rdc(fAddr(s), (a < 3 || (a == 3 ? m[7] : |(v & m))) ? fBit(s) : 8'h00);
            wr(fAddr(s), ~fBit(s));
            rdc(fAddr(s), 8'h00);
        end
        do begin
            a = $urandom % 18;
            b = $urandom % 18;
        end while (a % 6 == b % 6);
        la = $urandom % 4;
        do lb = $urandom % 4; while (lb == la);
        p = '0;
        {p[8 + a % 6], p[a % 6]} = 2'(la);
        {p[8 + b % 6], p[b % 6]} = 2'(lb);
        wr(OFS_PRIO0, p[7:0]);
        wr(OFS_PRIO1, p[15:8]);
        holdCyc <= 8'h28;
        setEn(24'h3F_3FBF);
        hi = (la > lb) ? a : b;
        lo = (la > lb) ? b : a;
        q.push_back(hi);
        q.push_back(lo);
        @(posedge sys_clk);
        srcEvt <= 18'(1 << a) | 18'(1 << b);
        @(posedge sys_clk);
        srcEvt <= '0;
        repeat (2) begin
            waitReq(100);
            `CHK(irqSrc, 5'(q.pop_front()))
            waitAck();
            repeat (20) @(negedge sys_clk);
            `CHK(irqReq, 1'b0)
        end
        for (n = 0; n < 100 && inService !== 1'b0; n++) @(negedge sys_clk);
        `CHK(inService, 1'b0)
        // The higher level must preempt a running lower-level service.
        @(posedge sys_clk);
        srcEvt <= 18'(1 << lo);
        @(posedge sys_clk);
        srcEvt <= '0;
        waitReq(20);
        `CHK(irqSrc, 5'(lo))
        waitAck();
        @(posedge sys_clk);
        srcEvt <= 18'(1 << hi);
        @(posedge sys_clk);
        srcEvt <= '0;
        waitReq(20);
        `CHK(irqSrc, 5'(hi))
        waitAck();
        // After the preempting routine returns, the preempted one is still in service.
        repeat (45) @(negedge sys_clk);
        `CHK(inService, 1'b1)
        for (n = 0; n < 100 && inService !== 1'b0; n++) @(negedge sys_clk);
        `CHK(inService, 1'b0)
        stop_test();
    end
endmodule
`default_nettype wire
